// ===== src/fsr_map.svh
// fsr_map.svh: offsets, field layouts and timing counts of the suspend sequencer
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH
// clock period in ns (125 MHz)
`define FSR_CLK_NS        8
// register byte addresses
`define FSR_A_CTRL        8'h00
`define FSR_A_STAT        8'h01
`define FSR_A_PRM         8'h2C
// command bits of the control register
`define FSR_C_ERS         0
`define FSR_C_PRG         1
`define FSR_C_SUSP        2
`define FSR_C_RES         3
// status bits
`define FSR_S_BUSY        0
`define FSR_S_ESUS        1
`define FSR_S_PSUS        2
`define FSR_S_SUSP        3
`define FSR_S_REFU        4
// fields of the suspend parameter word, msb first
`define FSR_F_SUP         1'h0
`define FSR_F_EUNIT       2'h2
`define FSR_F_ECNT        5'h04
`define FSR_F_EIVL        4'h1
`define FSR_F_PUNIT       2'h2
`define FSR_F_PCNT        5'h04
`define FSR_F_PIVL        4'h1
`define FSR_F_RFU         1'h1
`define FSR_F_EPROH       4'hE
`define FSR_F_PPROH       4'hC
`define FSR_WORD          32'h441883EC
// latency unit codes in ns
`define FSR_U0_NS         128
`define FSR_U1_NS         1000
`define FSR_U2_NS         8000
`define FSR_U3_NS         64000
`define FSR_IVL_UNIT_NS   64000
// internal work times in cycles
`define FSR_SETTLE_CYC    64
`define FSR_ERASE_CYC     20000
`define FSR_PROG_CYC      4000
`endif

// ===== src/fsr_param_rom.sv
// fsr_param_rom: byte-wide registered readout of the suspend parameter word
`timescale 1ns/1ps
`include "fsr_map.svh"
module fsr_param_rom
   import fsr_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // read request
   input  wire logic       rd_i,
   input  wire logic [1:0] idx_i,
   // read data, one cycle later
   output logic [7:0]      data_o
);
   // the word is assembled from its fields so each field has one home
   localparam logic [31:0] WORD = {`FSR_F_SUP, `FSR_F_EUNIT, `FSR_F_ECNT,
      `FSR_F_EIVL, `FSR_F_PUNIT, `FSR_F_PCNT, `FSR_F_PIVL, `FSR_F_RFU,
      `FSR_F_EPROH, `FSR_F_PPROH};

   logic [7:0] q_ff;    // registered read byte
   logic [7:0] nxt_q;   // next read byte

   // ----------------------------------------------------------------
   // byte select, least significant byte at the lowest offset
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_q = q_ff;
      if (rd_i)
      begin
         nxt_q = WORD[{idx_i, 3'h0} +: 8]; // RQ10
      end
   end

   // read register
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         q_ff <= 8'h00;
      else
         q_ff <= nxt_q;
   end

   assign data_o = q_ff;

   // checks of the published word
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   word_value_a: assert property (WORD == `FSR_WORD) // RQ10
      else $error("parameter word differs from published value");
   sup_bit_a: assert property (rd_i && idx_i == 2'h3 |=> !data_o[7]) // RQ1
      else $error("suspend support bit not zero");
   rfu_bit_a: assert property (rd_i && idx_i == 2'h1 |=> data_o[0]) // RQ11
      else $error("reserved bit 8 not one");
   byte_order_a: assert property (rd_i && idx_i == 2'h0 |=> data_o == 8'hEC) // RQ10
      else $error("lowest byte is not EC");
endmodule // fsr_param_rom

// ===== src/fsr_pkg.sv
// fsr_pkg: types and decode functions of the suspend sequencer
`include "fsr_map.svh"
package fsr_pkg;
   // register bus request carrier
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } fsr_bus_t;

   // sequencer states
   typedef enum logic [2:0] {
      S_IDLE, S_ERS, S_PRG, S_ERS_HALT, S_PRG_HALT,
      S_ERS_SUSP, S_PRG_SUSP, S_ESUS_PRG
   } fsr_state_t;

   // max latency = (count + 1) * unit
   function automatic int unsigned fsr_lat_ns(input logic [1:0] u, input logic [4:0] c);
      int unsigned un;
      un = (u == 2'h0) ? `FSR_U0_NS : (u == 2'h1) ? `FSR_U1_NS :
           (u == 2'h2) ? `FSR_U2_NS : `FSR_U3_NS;
      return (int'(c) + 1) * un;
   endfunction
endpackage

// ===== src/fsr_top.sv
// fsr_top: program and erase sequencer with suspend, resume and parameter readout
`timescale 1ns/1ps
`include "fsr_map.svh"
// How it works
// [RQ1] top word bit zero: suspend supported
// [RQ2] latency units 128ns, 1us, 8us, 64us
// [RQ3] erase suspends within 40 us
// [RQ4] host waits 128 us before erase resuspend
// [RQ5] program suspends within 40 us
// [RQ6] host waits 128 us before program resuspend
// [RQ7] no new erase while erase suspended
// [RQ8] no program in suspended erase sector
// [RQ9] nothing new started while program suspended
// [RQ10] word EC,83,18,44 from offset 2Ch
// [RQ11] reserved bit 8 reads one
// [RQ12] suspended state flagged; resume acts at once (a resume while a nested program runs in S_ESUS_PRG is refused)
module fsr_top
   import fsr_pkg::*;
#(
   parameter int unsigned ERS_SUSP_MAX_CYC =
      fsr_lat_ns(`FSR_F_EUNIT, `FSR_F_ECNT) / `FSR_CLK_NS,
   parameter int unsigned PRG_SUSP_MAX_CYC =
      fsr_lat_ns(`FSR_F_PUNIT, `FSR_F_PCNT) / `FSR_CLK_NS,
   parameter int unsigned ERASE_CYC        = `FSR_ERASE_CYC,
   parameter int unsigned PROG_CYC         = `FSR_PROG_CYC
)(
   // clock and reset
   input  wire logic     clk_i,
   input  wire logic     rst_i,
   // register bus
   input  wire fsr_bus_t bus_i,
   output logic [7:0]    rdata_o,
   // state flags
   output logic          busy_o,
   output logic          suspended_o
);
   // ----------------------------------------------------------------
   // constants
   // ----------------------------------------------------------------
   localparam int unsigned SETTLE = `FSR_SETTLE_CYC;
   // halt time is capped by the published max latency
   localparam int unsigned ELIM = (SETTLE < ERS_SUSP_MAX_CYC) ? SETTLE : ERS_SUSP_MAX_CYC;
   localparam int unsigned PLIM = (SETTLE < PRG_SUSP_MAX_CYC) ? SETTLE : PRG_SUSP_MAX_CYC;
   localparam int HB = 1000;   // assertion bound on the halt wait

   // all state of the sequencer
   typedef struct packed {
      fsr_state_t  st;     // sequencer state
      logic [23:0] ecnt;   // erase cycles left
      logic [23:0] pcnt;   // program cycles left
      logic [15:0] hcnt;   // halt cycles spent
      logic        refu;   // sticky refused command
      logic        rsel;   // read data come from the rom
      logic [7:0]  rdq;    // registered status read
   } fsr_regs_t;

   fsr_regs_t  r_ff;       // current state
   fsr_regs_t  nxt_r;      // next state
   logic [7:0] rom_q;      // parameter byte
   logic       rom_rd;     // parameter read strobe
   logic       cw;         // control write
   logic       ers;        // start erase command
   logic       prg;        // start program command
   logic       sus;        // suspend command
   logic       res;        // resume command
   logic       clr;        // refused flag clear
   logic       bad;        // command refused this cycle
   logic       esus;       // erase is suspended
   logic       psus;       // program is suspended
   logic [7:0] stat;       // status byte

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   assign cw     = bus_i.wr && bus_i.addr == `FSR_A_CTRL;
   assign ers    = cw && bus_i.wdata[`FSR_C_ERS];
   assign prg    = cw && bus_i.wdata[`FSR_C_PRG];
   assign sus    = cw && bus_i.wdata[`FSR_C_SUSP];
   assign res    = cw && bus_i.wdata[`FSR_C_RES];
   assign clr    = bus_i.wr && bus_i.addr == `FSR_A_STAT && bus_i.wdata[`FSR_S_REFU];
   assign rom_rd = bus_i.rd && bus_i.addr[7:2] == `FSR_A_PRM >> 2; // RQ10

   // a nested program keeps the erase counted as suspended
   assign esus = r_ff.st == S_ERS_SUSP || r_ff.st == S_ESUS_PRG; // RQ12
   assign psus = r_ff.st == S_PRG_SUSP; // RQ12

   // status byte, unused bits read zero
   always_comb
   begin
      stat = 8'h00;
      stat[`FSR_S_BUSY] = busy_o;
      stat[`FSR_S_ESUS] = esus;
      stat[`FSR_S_PSUS] = psus;
      stat[`FSR_S_SUSP] = esus || psus;
      stat[`FSR_S_REFU] = r_ff.refu;
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_r = r_ff;
      bad   = 1'b0;
      unique case (r_ff.st)
         // idle: only a start is meaningful
         S_IDLE:
         begin
            if (ers)
            begin
               nxt_r.st   = S_ERS;
               nxt_r.ecnt = 24'(ERASE_CYC - 1);
            end
            else if (prg)
            begin
               nxt_r.st   = S_PRG;
               nxt_r.pcnt = 24'(PROG_CYC - 1);
            end
            else if (sus || res)
               bad = 1'b1;
         end
         // erase running; resuspend spacing is left to the host
         S_ERS:
         begin
            if (sus) // RQ4
            begin
               nxt_r.st   = S_ERS_HALT;
               nxt_r.hcnt = 16'h0000;
            end
            else
            begin
               bad = ers || prg || res;
               if (r_ff.ecnt == 24'h000000)
                  nxt_r.st = S_IDLE;
               else
                  nxt_r.ecnt = r_ff.ecnt - 24'h000001;
            end
         end
         // program running
         S_PRG:
         begin
            if (sus) // RQ6
            begin
               nxt_r.st   = S_PRG_HALT;
               nxt_r.hcnt = 16'h0000;
            end
            else
            begin
               bad = ers || prg || res;
               if (r_ff.pcnt == 24'h000000)
                  nxt_r.st = S_IDLE;
               else
                  nxt_r.pcnt = r_ff.pcnt - 24'h000001;
            end
         end
         // erase halting, bounded by the max latency
         S_ERS_HALT:
         begin
            bad = cw;
            if (r_ff.hcnt == 16'(ELIM - 1)) // RQ3
               nxt_r.st = S_ERS_SUSP;
            else
               nxt_r.hcnt = r_ff.hcnt + 16'h0001;
         end
         // program halting
         S_PRG_HALT:
         begin
            bad = cw;
            if (r_ff.hcnt == 16'(PLIM - 1)) // RQ5
               nxt_r.st = S_PRG_SUSP;
            else
               nxt_r.hcnt = r_ff.hcnt + 16'h0001;
         end
         // erase suspended: resume, or program elsewhere
         S_ERS_SUSP:
         begin
            if (res) // RQ12
               nxt_r.st = S_ERS;
            else if (prg) // RQ8
            begin
               nxt_r.st   = S_ESUS_PRG;
               nxt_r.pcnt = 24'(PROG_CYC - 1);
            end
            else
               bad = ers || sus; // RQ7
         end
         // program inside an erase suspend; cannot itself be suspended
         S_ESUS_PRG:
         begin
            bad = cw;
            if (r_ff.pcnt == 24'h000000)
               nxt_r.st = S_ERS_SUSP;
            else
               nxt_r.pcnt = r_ff.pcnt - 24'h000001;
         end
         // program suspended: only resume
         S_PRG_SUSP:
         begin
            if (res) // RQ12
               nxt_r.st = S_PRG;
            else
               bad = ers || prg || sus; // RQ9
         end
      endcase
      // a refusal in the clearing cycle survives the clear
      nxt_r.refu = bad || (r_ff.refu && !clr);
      // read path: rom bytes or status, other addresses read zero
      nxt_r.rsel = rom_rd;
      nxt_r.rdq  = (bus_i.rd && bus_i.addr == `FSR_A_STAT) ? stat : 8'h00;
   end

   // state register
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         r_ff <= '{st: S_IDLE, ecnt: 24'h000000, pcnt: 24'h000000,
                   hcnt: 16'h0000, refu: 1'b0, rsel: 1'b0, rdq: 8'h00};
      else
         r_ff <= nxt_r;
   end

   // ----------------------------------------------------------------
   // parameter word readout
   // ----------------------------------------------------------------
   fsr_param_rom u_rom (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .rd_i   (rom_rd),
      .idx_i  (bus_i.addr[1:0]),
      .data_o (rom_q)
   );

   // outputs decode straight from the state register and the rom read register
   assign rdata_o     = r_ff.rsel ? rom_q : r_ff.rdq;
   assign busy_o      = r_ff.st inside {S_ERS, S_PRG, S_ERS_HALT, S_PRG_HALT, S_ESUS_PRG};
   assign suspended_o = esus || psus; // RQ12

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_ers_req;
      r_ff.st == S_ERS && sus;
   endsequence
   sequence s_prg_req;
      r_ff.st == S_PRG && sus;
   endsequence

   lat_code_a: assert property (fsr_lat_ns(2'h2, 5'h04) == 40000 && // RQ2
      fsr_lat_ns(2'h0, 5'h00) == 128 && fsr_lat_ns(2'h3, 5'h00) == 64000)
      else $error("latency unit decode wrong");
   ers_halt_a: assert property (s_ers_req |=> (r_ff.st == S_ERS_HALT) // RQ3
      ##[0:HB] (r_ff.st == S_ERS_SUSP && suspended_o))
      else $error("erase did not suspend in time");
   ers_bound_a: assert property (r_ff.st == S_ERS_HALT |-> // RQ3
      r_ff.hcnt < 16'(ERS_SUSP_MAX_CYC))
      else $error("erase halt beyond max latency");
   prg_halt_a: assert property (s_prg_req |=> (r_ff.st == S_PRG_HALT) // RQ5
      ##[0:HB] (r_ff.st == S_PRG_SUSP && suspended_o))
      else $error("program did not suspend in time");
   resume_a: assert property (suspended_o && res && !esus |=> // RQ12
      !suspended_o && busy_o)
      else $error("resume not taken at once");
   refuse_a: assert property (psus && ers |=> r_ff.refu && psus) // RQ9
      else $error("erase during program suspend not refused");
   prm_read_a: assert property (bus_i.rd && bus_i.addr == 8'h2F |=> // RQ10
      rdata_o == 8'h44)
      else $error("top parameter byte wrong");
endmodule // fsr_top

// ===== testbench/fsr_host.sv
// fsr_host: host controller model that issues register bus cycles to the sequencer
`timescale 1ns/1ps
`include "fsr_map.svh"
module fsr_host
   import fsr_pkg::*;
#(
   parameter int RESUSP_CYC = 16000            // 128 us in 8 ns cycles
)(
   // clock
   input  wire logic       clk_i,
   // bus towards the sequencer
   output fsr_bus_t        bus_o,
   input  wire logic [7:0] rdata_i
);
   int cyc_ff  = 0;                            // free running cycle count
   int res_ff  = 0;                            // cycle of the last resume
   bit resumed = 1'b0;                         // a resume has been sent
   initial bus_o = '0;

   // cycle count, used only to space a suspend after a resume
   always @(posedge clk_i) cyc_ff <= cyc_ff + 1;

   // one write cycle; a suspend too soon after resume would starve the operation
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      if (a == `FSR_A_CTRL && d[`FSR_C_SUSP] && resumed)
      begin
         while (cyc_ff - res_ff < RESUSP_CYC) @(posedge clk_i);
      end
      @(posedge clk_i);
      bus_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      bus_o <= '0;
      if (a == `FSR_A_CTRL && (d[`FSR_C_ERS] || d[`FSR_C_PRG]))
      begin
         // a new operation has never been resumed, so no spacing applies to it
         resumed = 1'b0;
      end
      if (a == `FSR_A_CTRL && d[`FSR_C_RES])
      begin
         // the operation counts as resumed once the command is taken
         res_ff  = cyc_ff;
         resumed = 1'b1;
      end
      // return where the flags launched by this write have settled
      @(negedge clk_i);
   endtask

   // one read cycle; data are taken in the single cycle where they stand
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      bus_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      bus_o <= '0;
      @(negedge clk_i);
      d = rdata_i;
   endtask
endmodule // fsr_host

// ===== testbench/fsr_top_bench.sv
// fsr_top_bench: self-checking bench of the suspend and resume sequencer
`timescale 1ns/1ps
`include "fsr_map.svh"
module fsr_top_bench;
   import fsr_pkg::*;
   localparam int          SUSP_MAX = 5000;          // 40 us in 8 ns cycles
   localparam logic [31:0] PWORD    = 32'h441883EC;  // expected parameter word
   logic       clk_i;                                // 125 MHz clock
   logic       rst_i;                                // async reset
   fsr_bus_t   bus;                                  // host bus
   logic [7:0] rdata;                                // read data
   logic       busy;                                 // busy flag
   logic       susp;                                 // suspended flag
   int         failures  = 0;                        // mismatch count
   int         tests_run = 0;                        // comparison count

   // short run times so that each operation ends in a few dozen cycles
   fsr_top #(.ERASE_CYC(40), .PROG_CYC(20)) i_fsr_top (.clk_i(clk_i), .rst_i(rst_i),
      .bus_i(bus), .rdata_o(rdata), .busy_o(busy), .suspended_o(susp));
   fsr_host i_fsr_host (.clk_i(clk_i), .bus_o(bus), .rdata_i(rdata));

   // clock generator
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // compare a byte
   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   // compare a flag
   task automatic chk1(input string n, input logic e, input logic g);
      tests_run++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value %s expected %b seen %b", n, e, g);
      end
   endtask

   // counts and verdict
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // bounded wait for suspended (sel 0) or busy (sel 1) to reach a level
   task automatic wait_flag(input bit sel, input logic want, input int max, output int n);
      n = 0;
      while ((sel ? busy : susp) !== want)
      begin
         @(negedge clk_i);
         n++;
         if (n > max)
         begin
            failures++;
            $display("wrong value wait flag expected %b seen timeout", want);
            tally_and_finish();
         end
      end
   endtask

   // read status and compare it
   task automatic stat(input string n, input logic [7:0] e);
      logic [7:0] b;
      i_fsr_host.rd(`FSR_A_STAT, b);
      chk8(n, e, b);
   endtask

   // parameter word fields, byte order, unmapped and write-only reads
   task automatic test_param();
      logic [7:0]  b;
      logic [31:0] w;
      for (int i = 0; i < 4; i++)
      begin
         i_fsr_host.rd(`FSR_A_PRM + 8'(i), b);
         w[8*i +: 8] = b;
         chk8("param byte", PWORD[8*i +: 8], b);
      end
      chk8("support bit", 8'h00, {7'h00, w[31]});
      chk8("erase unit", 8'h02, {6'h00, w[30:29]});
      chk8("erase count", 8'h04, {3'h0, w[28:24]});
      chk8("erase gap", 8'h01, {4'h0, w[23:20]});
      chk8("prog unit", 8'h02, {6'h00, w[19:18]});
      chk8("prog count", 8'h04, {3'h0, w[17:13]});
      chk8("prog gap", 8'h01, {4'h0, w[12:9]});
      chk8("reserved bit", 8'h01, {7'h00, w[8]});
      chk8("erase limits", 8'h0E, {4'h0, w[7:4]});
      chk8("prog limits", 8'h0C, {4'h0, w[3:0]});
      @(negedge clk_i);
      chk8("data after read", 8'h00, rdata);
      i_fsr_host.rd(8'h40, b);
      chk8("unmapped read", 8'h00, b);
      i_fsr_host.rd(`FSR_A_CTRL, b);
      chk8("control read", 8'h00, b);
      $display("test param done");
   endtask

   // erase, suspend, refused nested erase, nested program, resume
   task automatic test_erase();
      int n;
      i_fsr_host.wr(`FSR_A_CTRL, 8'h01);
      chk1("busy on erase", 1'b1, busy);
      i_fsr_host.wr(`FSR_A_CTRL, 8'h04);
      // the wait runs a little past the limit so that the check below judges it
      wait_flag(1'b0, 1'b1, SUSP_MAX + 8, n);
      chk1("erase halt in time", 1'b1, n <= SUSP_MAX);
      chk1("busy when halted", 1'b0, busy);
      stat("erase suspended", 8'h0A);
      // the host breaks the nesting limit on purpose here
      i_fsr_host.wr(`FSR_A_CTRL, 8'h01);
      stat("nested erase", 8'h1A);
      i_fsr_host.wr(`FSR_A_STAT, 8'h10);
      stat("refusal cleared", 8'h0A);
      i_fsr_host.wr(`FSR_A_CTRL, 8'h02);
      chk1("nested prog busy", 1'b1, busy);
      chk1("nested prog susp", 1'b1, susp);
      wait_flag(1'b1, 1'b0, 1000, n);
      stat("back to suspend", 8'h0A);
      i_fsr_host.wr(`FSR_A_CTRL, 8'h08);
      chk1("resumed susp", 1'b0, susp);
      chk1("resumed busy", 1'b1, busy);
      wait_flag(1'b1, 1'b0, 1000, n);
      stat("erase done", 8'h00);
      // a suspend with nothing running is refused
      i_fsr_host.wr(`FSR_A_CTRL, 8'h04);
      stat("suspend when idle", 8'h10);
      i_fsr_host.wr(`FSR_A_STAT, 8'h10);
      $display("test erase done");
   endtask

   // program, suspend, every new erase or program refused, resume
   task automatic test_prog();
      int         n;
      logic [7:0] cmd [2] = '{8'h01, 8'h02};
      i_fsr_host.wr(`FSR_A_CTRL, 8'h02);
      i_fsr_host.wr(`FSR_A_CTRL, 8'h04);
      wait_flag(1'b0, 1'b1, SUSP_MAX + 8, n);
      chk1("prog halt in time", 1'b1, n <= SUSP_MAX);
      stat("prog suspended", 8'h0C);
      foreach (cmd[i])
      begin
         i_fsr_host.wr(`FSR_A_CTRL, cmd[i]);
         stat("start in prog suspend", 8'h1C);
         i_fsr_host.wr(`FSR_A_STAT, 8'h10);
      end
      i_fsr_host.wr(`FSR_A_CTRL, 8'h08);
      chk1("prog resumed", 1'b0, susp);
      wait_flag(1'b1, 1'b0, 1000, n);
      stat("prog done", 8'h00);
      $display("test prog done");
   endtask

   // main sequence
   initial
   begin
      rst_i = 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      test_param();
      test_erase();
      test_prog();
      tally_and_finish();
   end
endmodule // fsr_top_bench
